// ===== rtl/fic_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fic_if;
   logic                           up_req;
   logic                           down_req;
   logic                           busy;
   logic [fic_pkg::NUM_RAILS-1:0]  rails;
   logic                           log_we;
   logic [fic_pkg::FAULT_W-1:0]    log_fault;
   logic [7:0]                     log_first;
   logic [7:0]                     log_count;
   logic [7:0]                     log_last;

   modport ctl (output up_req, down_req, log_we, log_fault,
                input busy, rails, log_first, log_count, log_last);
   modport seq (input up_req, down_req, output busy, rails);
   modport log (input log_we, log_fault, output log_first, log_count, log_last);
endinterface
`default_nettype wire

// ===== rtl/fic_log.sv
`timescale 1ns/100ps
`default_nettype none
module fic_log (
   input  wire logic ref_clk,
   input  wire logic srst,
   fic_if.log        bus
);
   // first entry keeps the oldest fault, last the newest; count saturates
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bus.log_first <= fic_pkg::LOG_RST;
         bus.log_count <= fic_pkg::LOG_RST;
         bus.log_last  <= fic_pkg::LOG_RST;
      end else if (bus.log_we) begin
         bus.log_last <= {3'h0, bus.log_fault};
         if (bus.log_count == fic_pkg::LOG_RST) begin
            bus.log_first <= {3'h0, bus.log_fault};
         end
         if (bus.log_count != fic_pkg::LOG_COUNT_MAX) begin
            bus.log_count <= bus.log_count + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ===== rtl/fic_pkg.sv
`default_nettype none
package fic_pkg;
   // register offsets on the sideband register port
   localparam logic [7:0] ADDR_LOG_FIRST = 8'h04;
   localparam logic [7:0] ADDR_LOG_COUNT = 8'h05;
   localparam logic [7:0] ADDR_LOG_LAST  = 8'h06;
   localparam logic [7:0] ADDR_STATUS    = 8'h08;
   localparam logic [7:0] ADDR_PROT_CFG  = 8'h2f;
   localparam logic [7:0] ADDR_INJ_CTL   = 8'h35;

   // field positions
   localparam int INJ_EN_BIT      = 7;
   localparam int PROT_PROG_BIT   = 2;
   localparam int STAT_SECURE_BIT = 7;
   localparam int STAT_INJ_BIT    = 6;
   localparam int STAT_ON_BIT     = 5;
   localparam int FAULT_W         = 5;
   localparam int NUM_RAILS       = 3;

   // reset values and the log count saturation limit
   localparam logic [7:0] PROT_CFG_RST  = 8'h00;
   localparam logic [7:0] LOG_RST       = 8'h00;
   localparam logic [7:0] LOG_COUNT_MAX = 8'hff;

   // rail sequencing step time and its cycle count at ref_clk
   localparam int CLK_PERIOD_NS = 50;
   localparam int STEP_TIME_NS  = 2000;
   localparam int STEP_CYC      = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] STEP_CNT_MAX = 8'(STEP_CYC - 1);

   typedef enum logic [2:0] {
      S_CONFIG,
      S_POWER_UP,
      S_ON,
      S_POWER_DOWN,
      S_OFF,
      S_BLOCKED
   } fic_state_t;
endpackage
`default_nettype wire

// ===== rtl/fic_seq.sv
`timescale 1ns/100ps
`default_nettype none
module fic_seq (
   input  wire logic ref_clk,
   input  wire logic srst,
   fic_if.seq        bus
);
   logic                          dir_up;
   logic [7:0]                    cnt;
   logic [fic_pkg::NUM_RAILS-1:0] next_rails;

   // one rail per step: up fills from rail 0, down drains from the top rail
   always_comb begin
      if (dir_up) begin
         next_rails = {bus.rails[fic_pkg::NUM_RAILS-2:0], 1'b1};
      end else begin
         next_rails = bus.rails >> 1;
      end
   end

   // requests are only taken when idle; a request while busy is dropped
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bus.rails <= '0;
         bus.busy  <= 1'b0;
         dir_up    <= 1'b0;
         cnt       <= 8'h00;
      end else if (!bus.busy) begin
         cnt <= 8'h00;
         if (bus.up_req) begin
            bus.busy <= 1'b1;
            dir_up   <= 1'b1;
         end else if (bus.down_req) begin
            bus.busy <= 1'b1;
            dir_up   <= 1'b0;
         end
      end else if (cnt == fic_pkg::STEP_CNT_MAX) begin
         cnt       <= 8'h00;
         bus.rails <= next_rails;
         if (next_rails == '0 || &next_rails) begin
            bus.busy <= 1'b0;
         end
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/fic_top.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: before enable, in config state, host arms injection via injection bit 7.
// R2: fault injected before enable blocks power-up; outputs stay off.
// R3: faults injected before enable never touch the error log.
// R4: injection before enable enters secure mode when protection bit 2 is zero.
// R5: after enable in programmable mode, host may arm injection via bit 7.
// R6: post-enable programmable fault runs power-off and logs error and status.
// R7: after enable in secure mode, arming is refused and faults ignored.
// R8: secure mode: no power-off, no log or status change from injection.
// R9: injection mode persists until bulk supply power cycle; writes never clear.
// R10: sticky armed flag cleared only by power-on reset; mode gates handling.
module fic_top (
   input  wire logic                          ref_clk,
   input  wire logic                          srst,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [7:0]                    reg_wdata,
   output logic      [7:0]                    reg_rdata,
   input  wire logic                          regulator_enable_command,
   output logic      [fic_pkg::NUM_RAILS-1:0] switcher_outputs,
   output logic                               secure_mode,
   output logic                               inj_mode
);
   ////////////////////////////////////////////////////////////////////////////
   // declarations
   fic_pkg::fic_state_t           state;
   fic_pkg::fic_state_t           next_state;
   logic [7:0]                    prot_cfg;
   logic [fic_pkg::FAULT_W-1:0]   inj_sel;
   logic [fic_pkg::FAULT_W-1:0]   fault_status;
   logic [fic_pkg::FAULT_W-1:0]   faults_new;
   logic                          pre_fault;
   logic                          wr_inj;
   logic                          inj_window;
   logic                          inj_accept;
   logic                          inj_fire;
   logic                          cmd_taken;

   fic_if ifc ();

   fic_seq u_fic_seq (
      .ref_clk (ref_clk),
      .srst    (srst),
      .bus     (ifc.seq)
   );

   fic_log u_fic_log (
      .ref_clk (ref_clk),
      .srst    (srst),
      .bus     (ifc.log)
   );

   ////////////////////////////////////////////////////////////////////////////
   // injection write qualification
   assign wr_inj     = reg_wr && (reg_addr == fic_pkg::ADDR_INJ_CTL);
   // injection is only open in config state or when on and programmable
   assign inj_window = (state == fic_pkg::S_CONFIG) ||
                       ((state == fic_pkg::S_ON) && !secure_mode);   // [R1] [R5] [R7]
   assign inj_accept = wr_inj && inj_window;                         // [R7]
   // a fault fires when the write arms injection or it is already armed
   assign faults_new = (inj_accept && (reg_wdata[fic_pkg::INJ_EN_BIT] || inj_mode)) ?
                       reg_wdata[fic_pkg::FAULT_W-1:0] : '0;         // [R10]
   assign inj_fire   = |faults_new;
   assign cmd_taken  = (state == fic_pkg::S_CONFIG) && regulator_enable_command;

   ////////////////////////////////////////////////////////////////////////////
   // sticky armed flag: only the bulk-supply reset clears it
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         inj_mode <= 1'b0;
      end else if (inj_accept && reg_wdata[fic_pkg::INJ_EN_BIT]) begin
         inj_mode <= 1'b1;                                           // [R9] [R10]
      end
   end

   // last accepted fault selection, kept for read-back
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         inj_sel <= '0;
      end else if (inj_accept) begin
         inj_sel <= reg_wdata[fic_pkg::FAULT_W-1:0];
      end
   end

   // fault armed before enable; remembered so the enable command is refused
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pre_fault <= 1'b0;
      end else if (inj_fire && (state == fic_pkg::S_CONFIG)) begin
         pre_fault <= 1'b1;                                          // [R2]
      end
   end

   // secure mode is one-way; it also freezes protection config writes
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         secure_mode <= 1'b0;
      end else if (!prot_cfg[fic_pkg::PROT_PROG_BIT] &&
                   (state == fic_pkg::S_CONFIG) && (inj_fire || regulator_enable_command)) begin
         secure_mode <= 1'b1;                                        // [R4]
      end
   end

   // protection config, writable until secure mode locks it
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prot_cfg <= fic_pkg::PROT_CFG_RST;
      end else if (reg_wr && (reg_addr == fic_pkg::ADDR_PROT_CFG) && !secure_mode) begin
         prot_cfg <= reg_wdata;
      end
   end

   // sticky fault status, set only by a logged post-enable fault
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fault_status <= '0;
      end else if (ifc.log_we) begin
         fault_status <= fault_status | faults_new;                  // [R6]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode state machine
   always_comb begin
      next_state = state;
      case (state)
         fic_pkg::S_CONFIG: begin
            if (regulator_enable_command) begin
               // a fault injected now or earlier keeps every rail off
               next_state = (pre_fault || inj_fire) ? fic_pkg::S_BLOCKED
                                                    : fic_pkg::S_POWER_UP;   // [R2]
            end
         end
         fic_pkg::S_POWER_UP: begin
            if (!ifc.busy && (&ifc.rails)) begin
               next_state = fic_pkg::S_ON;
            end
         end
         fic_pkg::S_ON: begin
            if (inj_fire) begin
               next_state = fic_pkg::S_POWER_DOWN;                   // [R6]
            end
         end
         fic_pkg::S_POWER_DOWN: begin
            if (!ifc.busy && (ifc.rails == '0)) begin
               next_state = fic_pkg::S_OFF;
            end
         end
         fic_pkg::S_OFF:     next_state = fic_pkg::S_OFF;
         fic_pkg::S_BLOCKED: next_state = fic_pkg::S_BLOCKED;
         default:            next_state = fic_pkg::S_CONFIG;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= fic_pkg::S_CONFIG;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer and log requests
   assign ifc.up_req    = cmd_taken && !pre_fault && !inj_fire;      // [R2]
   // only a post-enable programmable fault reaches power-off and the log
   assign ifc.down_req  = (state == fic_pkg::S_ON) && inj_fire;      // [R6] [R8]
   assign ifc.log_we    = (state == fic_pkg::S_ON) && inj_fire;      // [R3] [R6]
   assign ifc.log_fault = faults_new;
   assign switcher_outputs = ifc.rails;

   ////////////////////////////////////////////////////////////////////////////
   // register read port: one cycle latency, unmapped offsets read zero
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            fic_pkg::ADDR_LOG_FIRST: reg_rdata <= ifc.log_first;
            fic_pkg::ADDR_LOG_COUNT: reg_rdata <= ifc.log_count;
            fic_pkg::ADDR_LOG_LAST:  reg_rdata <= ifc.log_last;
            fic_pkg::ADDR_STATUS:    reg_rdata <= {secure_mode, inj_mode,
                                                   (state == fic_pkg::S_ON), fault_status};
            fic_pkg::ADDR_PROT_CFG:  reg_rdata <= prot_cfg;
            fic_pkg::ADDR_INJ_CTL:   reg_rdata <= {inj_mode, 2'h0, inj_sel};  // [R9]
            default:                 reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   localparam int A_OFF_MAX = 140;
   localparam int A_ON_MAX  = 140;

   default clocking a_clk @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   sequence s_post_fault;
      (state == fic_pkg::S_ON) && inj_fire;
   endsequence

   sequence s_rails_off;
      ##[1:A_OFF_MAX] (switcher_outputs == '0);
   endsequence

   a_arm_config: assert property ( // [R1]
      ((state == fic_pkg::S_CONFIG) && wr_inj && reg_wdata[fic_pkg::INJ_EN_BIT]) |=> inj_mode)
      else $error("arming in config state was not taken");

   a_block_power_up: assert property ( // [R2]
      (pre_fault && regulator_enable_command) |=>
         (switcher_outputs == '0)[*8] ##0 (state == fic_pkg::S_BLOCKED))
      else $error("rails rose after pre-enable injection");

   a_log_frozen: assert property ( // [R3]
      pre_fault |=> ($stable(ifc.log_count) && $stable(ifc.log_last) && $stable(ifc.log_first)))
      else $error("error log changed after pre-enable injection");

   a_secure_entry: assert property ( // [R4]
      ((state == fic_pkg::S_CONFIG) && inj_fire && !prot_cfg[fic_pkg::PROT_PROG_BIT])
         |=> secure_mode)
      else $error("secure mode not entered after pre-enable injection");

   a_arm_program: assert property ( // [R5]
      ((state == fic_pkg::S_ON) && !secure_mode && wr_inj && reg_wdata[fic_pkg::INJ_EN_BIT])
         |=> inj_mode)
      else $error("arming in programmable mode was not taken");

   a_power_off_log: assert property ( // [R6]
      s_post_fault |=> (state == fic_pkg::S_POWER_DOWN) &&
         (fault_status == $past(fault_status | faults_new)) &&
         (ifc.log_last == {3'h0, $past(faults_new)}) ##0 s_rails_off)
      else $error("post-enable fault did not power off and log");

   a_secure_refuse: assert property ( // [R7]
      ((state == fic_pkg::S_ON) && secure_mode && !inj_mode && wr_inj) |=> !inj_mode)
      else $error("injection armed while secure");

   a_secure_quiet: assert property ( // [R8]
      ((state == fic_pkg::S_ON) && secure_mode) |=>
         ($stable(fault_status) && $stable(ifc.log_count) && $stable(switcher_outputs)))
      else $error("secure mode injection changed outputs or logs");

   a_inj_sticky: assert property ( // [R9]
      inj_mode |=> inj_mode)
      else $error("injection mode left without power cycle");

   a_mode_gate: assert property ( // [R10]
      inj_fire |-> ((state == fic_pkg::S_CONFIG) ||
                    ((state == fic_pkg::S_ON) && !secure_mode)))
      else $error("injection handled outside an open mode");

   // writes outside the open windows must never arm the sticky flag
   a_arm_closed: assert property ( // [R7] [R10]
      (wr_inj && !inj_window && !inj_mode) |=> !inj_mode)
      else $error("injection armed outside an open window");

   // a blocked or finished part must show every rail off
   a_blocked_dark: assert property ( // [R2]
      (state == fic_pkg::S_BLOCKED) |-> (switcher_outputs == '0))
      else $error("rail on after blocked power-up");

   a_off_dark: assert property ( // [R6]
      (state == fic_pkg::S_OFF) |-> (switcher_outputs == '0))
      else $error("rail on after fault power-off");

   // rails fill from rail 0 and drain from the top, never leaving a gap
   a_rail_order: assert property ( // [R6]
      (switcher_outputs == 3'h0) || (switcher_outputs == 3'h1) ||
      (switcher_outputs == 3'h3) || (switcher_outputs == 3'h7))
      else $error("rails out of sequence order");

   // without an injected fault the enable command must bring every rail up
   sequence s_rails_on;
      ##[1:A_ON_MAX] (&switcher_outputs);
   endsequence

   a_power_up: assert property ( // [R2]
      ifc.up_req |=> (state == fic_pkg::S_POWER_UP) ##0 s_rails_on)
      else $error("clean enable did not bring the rails up");

   // only a programmable on state with no pre-enable fault may touch the log
   a_log_gate: assert property ( // [R3] [R8]
      ifc.log_we |-> ((state == fic_pkg::S_ON) && !secure_mode && !pre_fault))
      else $error("error log written outside programmable on state");

   sequence s_log_write;
      ifc.log_we && (ifc.log_count != fic_pkg::LOG_COUNT_MAX);
   endsequence

   a_log_count: assert property ( // [R6]
      s_log_write |=> (ifc.log_count == ($past(ifc.log_count) + 8'h01)))
      else $error("error log count did not advance");

   // status fault bits only ever gain bits until the bulk-supply reset
   a_status_sticky: assert property ( // [R6]
      (fault_status != '0) |=> ((fault_status & $past(fault_status)) == $past(fault_status)))
      else $error("fault status bit dropped without reset");

   // secure mode is one-way and freezes the protection config behind it
   a_secure_sticky: assert property ( // [R4]
      secure_mode |=> (secure_mode && $stable(prot_cfg)))
      else $error("secure mode left or protection config changed");

   // a set programmable bit keeps the part out of secure mode
   a_prog_kept: assert property ( // [R4]
      (prot_cfg[fic_pkg::PROT_PROG_BIT] && !secure_mode) |=> !secure_mode)
      else $error("secure mode entered with programmable bit set");
endmodule
`default_nettype wire

// ===== verif/fic_host.sv
`timescale 1ns/100ps
`default_nettype none
// host model on the register port; it changes its lines on the falling edge
module fic_host (
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   // idle bus at time zero
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one write: strobe held across exactly one rising edge
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(negedge ref_clk);
      reg_wr    = 1'b1;
      reg_addr  = addr;
      reg_wdata = data;
      @(negedge ref_clk);
      reg_wr    = 1'b0;
      reg_addr  = ~addr;  // released lines never keep the old value
      reg_wdata = ~data;
   endtask

   // one read: data is registered, so it is taken a full cycle after the strobe
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(negedge ref_clk);
      reg_rd   = 1'b1;
      reg_addr = addr;
      @(negedge ref_clk);
      reg_rd   = 1'b0;
      reg_addr = ~addr;
      @(negedge ref_clk);
      data = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ===== verif/fic_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fic_top_tb;
   logic                          ref_clk;
   logic                          srst;
   logic                          reg_wr;
   logic                          reg_rd;
   logic [7:0]                    reg_addr;
   logic [7:0]                    reg_wdata;
   logic [7:0]                    reg_rdata;
   logic                          cmd;
   logic [fic_pkg::NUM_RAILS-1:0] rails;
   logic                          secure_mode;
   logic                          inj_mode;
   logic [7:0]                    d;
   logic [7:0]                    fault;
   int                            fail_count = 0;
   int                            n_tests    = 0;
   logic [7:0] regs [7] = '{fic_pkg::ADDR_LOG_FIRST, fic_pkg::ADDR_LOG_COUNT,
      fic_pkg::ADDR_LOG_LAST, fic_pkg::ADDR_STATUS, fic_pkg::ADDR_PROT_CFG,
      fic_pkg::ADDR_INJ_CTL, 8'h10};

   fic_top u_fic_top (
      .ref_clk                  (ref_clk),
      .srst                     (srst),
      .reg_wr                   (reg_wr),
      .reg_rd                   (reg_rd),
      .reg_addr                 (reg_addr),
      .reg_wdata                (reg_wdata),
      .reg_rdata                (reg_rdata),
      .regulator_enable_command (cmd),
      .switcher_outputs         (rails),
      .secure_mode              (secure_mode),
      .inj_mode                 (inj_mode)
   );
   fic_host u_fic_host (
      .ref_clk   (ref_clk),
      .reg_rdata (reg_rdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // 20 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // bulk power cycle: the only way out of injection mode
   task automatic power_cycle();
      @(negedge ref_clk);
      srst = 1'b1;
      repeat (3) @(negedge ref_clk);
      srst = 1'b0;
   endtask

   task automatic enable();
      @(negedge ref_clk);
      cmd = 1'b1;
      @(negedge ref_clk);
      cmd = 1'b0;
   endtask

   // the whole run is some 3200 cycles; a hang is cut well beyond that
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      srst = 1'b1;
      cmd  = 1'b0;
      repeat (3) @(negedge ref_clk);
      srst = 1'b0;
      // every register clears at power-on, unmapped place reads zero
      foreach (regs[i]) begin
         u_fic_host.rd(regs[i], d);
         check("reset value", d, 8'h00);
      end
      // pre-enable injection of each fault kind blocks power-up, log untouched
      for (int i = 0; i < fic_pkg::FAULT_W; i++) begin
         power_cycle();
         check("inj_mode after power cycle", {7'h00, inj_mode}, 8'h00);
         fault = 8'h01 << i;
         u_fic_host.wr(fic_pkg::ADDR_INJ_CTL, 8'h80 | fault);
         u_fic_host.wr(fic_pkg::ADDR_INJ_CTL, 8'h00); // a zero must not disarm
         u_fic_host.rd(fic_pkg::ADDR_INJ_CTL, d);
         check("arm bit", d & 8'h80, 8'h80);
         check("inj_mode", {7'h00, inj_mode}, 8'h01);
         enable();
         repeat (130) @(negedge ref_clk);
         check("rails blocked", {5'h00, rails}, 8'h00);
         check("secure entered", {7'h00, secure_mode}, 8'h01);
         for (int k = 0; k < 3; k++) begin
            u_fic_host.rd(regs[k], d);
            check("log untouched", d, 8'h00);
         end
      end
      // programmable mode: injection after enable powers down and logs
      for (int i = 0; i < fic_pkg::FAULT_W; i++) begin
         power_cycle();
         fault = 8'h01 << i;
         u_fic_host.wr(fic_pkg::ADDR_PROT_CFG, 8'h04);
         // odd passes arm early with no fault, then fire later with the arm bit clear
         if (i % 2 == 1) begin
            u_fic_host.wr(fic_pkg::ADDR_INJ_CTL, 8'h80);
         end
         enable();
         repeat (130) @(negedge ref_clk);
         check("rails up", {5'h00, rails}, 8'h07);
         check("programmable", {7'h00, secure_mode}, 8'h00);
         u_fic_host.wr(fic_pkg::ADDR_INJ_CTL, ((i % 2 == 1) ? 8'h00 : 8'h80) | fault);
         repeat (59) @(negedge ref_clk);
         check("rails stepping down", {5'h00, rails}, 8'h03);
         repeat (80) @(negedge ref_clk);
         check("rails off", {5'h00, rails}, 8'h00);
         u_fic_host.wr(fic_pkg::ADDR_LOG_FIRST, 8'hff); // log is read-only
         u_fic_host.rd(fic_pkg::ADDR_LOG_FIRST, d);
         check("log first", d, fault);
         u_fic_host.rd(fic_pkg::ADDR_LOG_COUNT, d);
         check("log count", d, 8'h01);
         u_fic_host.rd(fic_pkg::ADDR_LOG_LAST, d);
         check("log last", d, fault);
         u_fic_host.rd(fic_pkg::ADDR_STATUS, d);
         check("status faults", d & 8'h1f, fault);
         check("status armed", d & 8'h40, 8'h40);
         enable();  // a second enable in one power cycle is ignored
         repeat (130) @(negedge ref_clk);
         check("rails stay off", {5'h00, rails}, 8'h00);
      end
      // secure mode after enable: arming refused, nothing changes
      power_cycle();
      enable();
      repeat (130) @(negedge ref_clk);
      check("rails up secure", {5'h00, rails}, 8'h07);
      check("secure", {7'h00, secure_mode}, 8'h01);
      u_fic_host.wr(fic_pkg::ADDR_INJ_CTL, 8'h81);
      check("arming refused", {7'h00, inj_mode}, 8'h00);
      repeat (130) @(negedge ref_clk);
      check("no power-off", {5'h00, rails}, 8'h07);
      u_fic_host.rd(fic_pkg::ADDR_LOG_COUNT, d);
      check("log count secure", d, 8'h00);
      u_fic_host.rd(fic_pkg::ADDR_LOG_LAST, d);
      check("log last secure", d, 8'h00);
      u_fic_host.rd(fic_pkg::ADDR_STATUS, d);
      check("status secure", d, 8'ha0);
      u_fic_host.wr(fic_pkg::ADDR_PROT_CFG, 8'h04);
      u_fic_host.rd(fic_pkg::ADDR_PROT_CFG, d);
      check("protection locked", d, 8'h00);
      end_of_test();
   end
endmodule
`default_nettype wire
